// file: rts_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef RTS_REGS_SVH
`define RTS_REGS_SVH

// Register byte offsets on the APB
`define RTS_CFG_OFS 12'h000
`define RTS_STAT_OFS 12'h004
`define RTS_PCS_OFS 12'h008

// Configuration register fields and reset value
`define RTS_CFG_OSC_LO 0
`define RTS_CFG_DELAY_BIT 2
`define RTS_CFG_BROWNOUT_BIT 3
`define RTS_CFG_RST 4'hD

// Status register fields
`define RTS_STAT_EXPIRED_BIT 0
`define RTS_STAT_SLEEP_BIT 1
`define RTS_STAT_INRESET_BIT 2
`define RTS_STAT_STALL_BIT 3
`define RTS_STAT_CAUSE_LO 4

// Power control status fields
`define RTS_PCS_BROWNOUT_BIT 0
`define RTS_PCS_POWERON_BIT 1

// Timing
`define RTS_CORE_CLK_HZ 100000000
`define RTS_DELAY_TIME_MS 72
`define RTS_DELAY_OSC_KHZ 100
`define RTS_DELAY_TICKS (`RTS_DELAY_TIME_MS * `RTS_DELAY_OSC_KHZ)
`define RTS_STARTUP_CYCLES 1024
`define RTS_BROWNOUT_MIN_US 100
`define RTS_BROWNOUT_MIN_CYC \
  (`RTS_BROWNOUT_MIN_US * (`RTS_CORE_CLK_HZ / 1000000))
`define RTS_CLEAR_FILT_NS 200
`define RTS_CLEAR_FILT_CYC \
  ((`RTS_CLEAR_FILT_NS * (`RTS_CORE_CLK_HZ / 1000000) + 999) / 1000)

`endif

// file: rts_pkg.sv
// Types shared by the reset sequencer modules
package rts_pkg;

  // Oscillator select codes
  typedef enum logic [1:0] {
    OSC_LOW_POWER = 2'h0,
    OSC_STANDARD = 2'h1,
    OSC_HIGH_SPEED = 2'h2,
    OSC_RES_CAP = 2'h3
  } rts_osc_t;

  // Recorded reset causes
  typedef enum logic [2:0] {
    CAUSE_POWER_ON,
    CAUSE_CLEAR_RUN,
    CAUSE_CLEAR_SLEEP,
    CAUSE_WATCHDOG,
    CAUSE_BROWNOUT
  } rts_cause_t;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_START,
    SEQ_DELAY,
    SEQ_STARTUP,
    SEQ_BROWNOUT,
    SEQ_RUN,
    SEQ_WAKE
  } rts_seq_t;

endpackage : rts_pkg

// file: rts_count_if.sv
// Control link between the sequencer and an edge counter
`timescale 1ns/1ns
interface rts_count_if;
  logic run;      // Count while high, clear while low
  logic done;     // Terminal count reached while running
  logic edgeSeen; // One-cycle pulse per rising input edge

  modport ctrl (output run, input done, input edgeSeen);
  modport cnt (input run, output done, output edgeSeen);
endinterface : rts_count_if

// file: rts_edge_counter.sv
// Counter of synchronised rising edges of an outside oscillator pin
`timescale 1ns/1ns
module rts_edge_counter
  import rts_pkg::*;
#(
  parameter int TERM = 1024 // Edges to count before done
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic oscPin,
  rts_count_if.cnt bus
);

  localparam int CW = $clog2(TERM + 1);

  logic [1:0] oscSync; // Two-stage synchroniser
  logic oscLast;       // Previous synchronised level
  logic [CW-1:0] count; // Edges seen in this run

  ////////////////////////////////////////////////////////////////////////
  // Synchronise the pin, then keep a copy for edge detection
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscSync <= 2'h0;
    end else begin
      oscSync <= {oscSync[0], oscPin};
    end
  end

  // Delayed copy of the clean level
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscLast <= 1'b0;
    end else begin
      oscLast <= oscSync[1];
    end
  end

  // Rising edge of either a crystal or an external clock source
  assign bus.edgeSeen = oscSync[1] & ~oscLast;

  ////////////////////////////////////////////////////////////////////////
  // Count edges while running; stop at the terminal count
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (!bus.run) begin
      count <= '0;
    end else if (bus.edgeSeen && count != CW'(TERM)) begin
      count <= count + CW'(1);
    end
  end

  // Done only while the run request stands
  assign bus.done = bus.run && (count == CW'(TERM));

endmodule : rts_edge_counter

// file: rts_sequencer.sv
// Reset and start-up sequencer with its APB register slave
`timescale 1ns/1ns
`include "rts_regs.svh"
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int DELAY_TICKS = `RTS_DELAY_TICKS,
  parameter int STARTUP_CYCLES = `RTS_STARTUP_CYCLES,
  parameter int BROWNOUT_MIN_CYC = `RTS_BROWNOUT_MIN_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic masterClearPin_b,
  input wire logic oscillatorInputPin,
  input wire logic delayOscPin,
  input wire logic brownoutSupplyLow,
  input wire logic watchdogReset,
  input wire logic watchdogWake,
  input wire logic interruptWake,
  input wire logic coreSleeping,
  output logic coreReset_b,
  output logic coreStall,
  output logic oscillatorOutputPin,
  output logic oscillatorOutputEn,
  output rts_cause_t resetCause
);

  localparam int CLEAR_FILT = `RTS_CLEAR_FILT_CYC;
  localparam int FW = $clog2(CLEAR_FILT + 1);
  localparam int BW = $clog2(BROWNOUT_MIN_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // Address match, used by decode, read and write paths
  function automatic logic regHit(
    input logic [11:0] addr,
    input logic [11:0] ofs
  );
    regHit = (addr == ofs);
  endfunction : regHit

  // Configuration and status storage
  logic [3:0] cfg;              // Oscillator, delay and brownout enables
  logic watchdogExpiredFlag;    // Cleared by watchdog events
  logic sleepEnteredFlag;       // Cleared by sleep related events
  logic brownoutStatus;         // Cleared by brownout reset
  logic powerOnStatus;          // Cleared by power-on only

  // Derived configuration
  rts_osc_t oscMode;            // Selected oscillator mode
  logic crystalMode;            // Any of the three crystal modes
  logic delayOn;                // Delay timer takes part
  logic brownoutEnableBit;      // Brownout detection enabled
  logic powerUpDelayEnableBit;  // Zero enables the delay timer

  // Pin synchronisers and filters
  logic [1:0] clearSync;        // Master clear pin synchroniser
  logic [1:0] lowSync;          // Supply-low detector synchroniser
  logic [FW-1:0] clearLowCnt;   // Cycles the pin has stayed low
  logic clearActive;            // Filtered master clear level
  logic clearEnter;             // Pulse as the filter trips
  logic [BW-1:0] lowCnt;        // Cycles the supply has stayed low
  logic brownoutActive;         // Brownout reset in force
  logic brownoutTrip;           // Pulse as brownout trips

  // Sequencer
  rts_seq_t state;              // Current step
  rts_seq_t next_state;         // Step for the next edge
  logic powerOnSeq;             // Sequence began at power-on
  logic inReset;                // Step that holds the core
  logic wakeEvent;              // Wake from sleep requested

  // Clock-out divider
  logic [1:0] divCnt;           // Oscillator edges modulo four

  // APB strobes
  logic apbSetup;               // Setup cycle of a transfer
  logic apbWrite;               // Write access phase
  logic apbMapped;              // Address hits a register
  logic [31:0] readMux;         // Read value of the addressed word

  // Edge counter links
  rts_count_if delayBus ();
  rts_count_if startBus ();

  ////////////////////////////////////////////////////////////////////////
  // Configuration decode
  assign oscMode = rts_osc_t'(cfg[`RTS_CFG_OSC_LO +: 2]);
  assign crystalMode = (oscMode != OSC_RES_CAP);
  assign powerUpDelayEnableBit = cfg[`RTS_CFG_DELAY_BIT];
  assign brownoutEnableBit = cfg[`RTS_CFG_BROWNOUT_BIT];
  // Delay runs if enabled, or always while brownout is on
  assign delayOn = ~powerUpDelayEnableBit | brownoutEnableBit;

  ////////////////////////////////////////////////////////////////////////
  // Master clear pin synchroniser, idle high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clearSync <= 2'h3;
    end else begin
      clearSync <= {clearSync[0], masterClearPin_b};
    end
  end

  // Supply-low detector synchroniser
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowSync <= 2'h0;
    end else begin
      lowSync <= {lowSync[0], brownoutSupplyLow};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master clear filter: pin must stay low for the filter time
  assign clearEnter = ~clearSync[1] & ~clearActive &
                      (clearLowCnt == FW'(CLEAR_FILT));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clearLowCnt <= '0;
      clearActive <= 1'b0;
    end else if (clearSync[1]) begin
      // Release acts at once, no filtering
      clearLowCnt <= '0;
      clearActive <= 1'b0;
    end else if (clearLowCnt == FW'(CLEAR_FILT)) begin
      clearActive <= 1'b1;
    end else begin
      clearLowCnt <= clearLowCnt + FW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Brownout detection: low longer than the minimum duration trips
  assign brownoutTrip = lowSync[1] & brownoutEnableBit & ~brownoutActive &
                        (lowCnt == BW'(BROWNOUT_MIN_CYC));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt <= '0;
      brownoutActive <= 1'b0;
    end else if (!lowSync[1] || !brownoutEnableBit) begin
      // Supply recovered or detection off
      lowCnt <= '0;
      brownoutActive <= 1'b0;
    end else if (lowCnt == BW'(BROWNOUT_MIN_CYC)) begin
      brownoutActive <= 1'b1;
    end else begin
      lowCnt <= lowCnt + BW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delay timer on its own oscillator pin
  rts_edge_counter #(
    .TERM(DELAY_TICKS)
  ) delayTimer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .oscPin(delayOscPin),
    .bus(delayBus.cnt)
  );

  // Startup counter on the main oscillator input
  rts_edge_counter #(
    .TERM(STARTUP_CYCLES)
  ) startupCounter (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .oscPin(oscillatorInputPin),
    .bus(startBus.cnt)
  );

  // Run requests follow the sequencer step
  assign delayBus.run = (state == SEQ_DELAY);
  assign startBus.run = (state == SEQ_STARTUP) || (state == SEQ_WAKE);

  assign wakeEvent = watchdogWake | interruptWake;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next step
  always_comb begin
    next_state = state;
    case (state)
      SEQ_START: begin
        if (brownoutActive) begin
          next_state = SEQ_BROWNOUT;
        end else if (delayOn) begin
          next_state = SEQ_DELAY;
        end else if (crystalMode) begin
          next_state = SEQ_STARTUP;
        end else begin
          next_state = SEQ_RUN;
        end
      end
      SEQ_DELAY: begin
        if (brownoutActive) begin
          next_state = SEQ_BROWNOUT;
        end else if (delayBus.done) begin
          // Startup count only after a power-on in crystal modes
          if (powerOnSeq && crystalMode) begin
            next_state = SEQ_STARTUP;
          end else begin
            next_state = SEQ_RUN;
          end
        end
      end
      SEQ_STARTUP: begin
        if (brownoutActive) begin
          next_state = SEQ_BROWNOUT;
        end else if (startBus.done) begin
          next_state = SEQ_RUN;
        end
      end
      SEQ_BROWNOUT: begin
        // Recovery always passes through a cleared delay
        if (!brownoutActive) begin
          next_state = SEQ_DELAY;
        end
      end
      SEQ_RUN: begin
        if (brownoutActive) begin
          next_state = SEQ_BROWNOUT;
        end else if (wakeEvent && crystalMode) begin
          next_state = SEQ_WAKE;
        end
      end
      SEQ_WAKE: begin
        if (brownoutActive) begin
          next_state = SEQ_BROWNOUT;
        end else if (startBus.done) begin
          next_state = SEQ_RUN;
        end
      end
      default: begin
        next_state = SEQ_START;
      end
    endcase
  end

  // Sequencer step register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SEQ_START;
    end else begin
      state <= next_state;
    end
  end

  // Power-on origin; lost once a brownout takes over
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      powerOnSeq <= 1'b1;
    end else if (state == SEQ_BROWNOUT) begin
      powerOnSeq <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core reset and stall outputs
  assign inReset = (state == SEQ_START) || (state == SEQ_DELAY) ||
                   (state == SEQ_STARTUP) || (state == SEQ_BROWNOUT);

  // Watchdog reset acts on the core only, the pin is never driven
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      coreReset_b <= 1'b0;
    end else begin
      coreReset_b <= ~(clearActive | watchdogReset |
                       brownoutActive | inReset);
    end
  end

  // Core clock stalled during the wake startup count
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      coreStall <= 1'b0;
    end else begin
      coreStall <= (next_state == SEQ_WAKE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset cause record; brownout outranks master clear and watchdog
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resetCause <= CAUSE_POWER_ON;
    end else if (brownoutTrip) begin
      resetCause <= CAUSE_BROWNOUT;
    end else if (clearEnter) begin
      resetCause <= coreSleeping ? CAUSE_CLEAR_SLEEP : CAUSE_CLEAR_RUN;
    end else if (watchdogReset) begin
      resetCause <= CAUSE_WATCHDOG;
    end
  end

  // Watchdog expired flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdogExpiredFlag <= 1'b1;
    end else if (watchdogReset || watchdogWake) begin
      watchdogExpiredFlag <= 1'b0;
    end
  end

  // Sleep entered flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sleepEnteredFlag <= 1'b1;
    end else if (watchdogWake || interruptWake ||
                 (clearEnter && coreSleeping)) begin
      sleepEnteredFlag <= 1'b0;
    end
  end

  // Power-on status: cleared only by power-on, software sets it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      powerOnStatus <= 1'b0;
    end else if (apbWrite && regHit(paddr, `RTS_PCS_OFS) &&
                 pwdata[`RTS_PCS_POWERON_BIT]) begin
      powerOnStatus <= 1'b1;
    end
  end

  // Brownout status: a trip wins over a software set
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      brownoutStatus <= 1'b0;
    end else if (brownoutTrip) begin
      brownoutStatus <= 1'b0;
    end else if (apbWrite && regHit(paddr, `RTS_PCS_OFS) &&
                 pwdata[`RTS_PCS_BROWNOUT_BIT]) begin
      brownoutStatus <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock-out divider on main oscillator edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt <= 2'h0;
    end else if (startBus.edgeSeen) begin
      divCnt <= divCnt + 2'h1;
    end
  end

  // Registered divided clock
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscillatorOutputPin <= 1'b0;
    end else begin
      oscillatorOutputPin <= divCnt[1];
    end
  end

  // Pin driven only in resistor-capacitor mode
  assign oscillatorOutputEn = (oscMode == OSC_RES_CAP);

  ////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, error on unmapped words
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  assign apbMapped = regHit(paddr, `RTS_CFG_OFS) ||
                     regHit(paddr, `RTS_STAT_OFS) ||
                     regHit(paddr, `RTS_PCS_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~apbMapped;

  // Read value of the addressed register
  always_comb begin
    readMux = 32'h0;
    if (regHit(paddr, `RTS_CFG_OFS)) begin
      readMux[3:0] = cfg;
    end else if (regHit(paddr, `RTS_STAT_OFS)) begin
      readMux[`RTS_STAT_EXPIRED_BIT] = watchdogExpiredFlag;
      readMux[`RTS_STAT_SLEEP_BIT] = sleepEnteredFlag;
      readMux[`RTS_STAT_INRESET_BIT] = ~coreReset_b;
      readMux[`RTS_STAT_STALL_BIT] = coreStall;
      readMux[`RTS_STAT_CAUSE_LO +: 3] = resetCause;
    end else if (regHit(paddr, `RTS_PCS_OFS)) begin
      readMux[`RTS_PCS_BROWNOUT_BIT] = brownoutStatus;
      readMux[`RTS_PCS_POWERON_BIT] = powerOnStatus;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
    end else if (apbSetup && !pwrite) begin
      prdata <= readMux;
    end
  end

  // Configuration write takes effect at the access edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= `RTS_CFG_RST;
    end else if (apbWrite && regHit(paddr, `RTS_CFG_OFS)) begin
      cfg <= pwdata[3:0];
    end
  end

endmodule : rts_sequencer

// file: rts_sequencer_assertions.sv
// Port-level checker for the reset sequencer
`timescale 1ns/1ns
module rts_sequencer_assertions
  import rts_pkg::*;
#(
  parameter int BROWNOUT_MIN_CYC = 5
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic masterClearPin_b,
  input wire logic brownoutSupplyLow,
  input wire logic watchdogReset,
  input wire logic coreReset_b,
  input wire logic oscillatorOutputEn,
  input wire rts_cause_t resetCause
);
  localparam int BO_LIM = BROWNOUT_MIN_CYC + 8; // Trip bound with slack
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] clrCnt; // Cycles the clear pin sat low
  logic [15:0] supCnt; // Cycles the supply sat low
  logic [3:0] cfg; // Shadow of the configuration word

  // Low-time counters and configuration shadow
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clrCnt <= 8'h00;
      supCnt <= 16'h0000;
      cfg <= 4'hD;
    end else begin
      clrCnt <= masterClearPin_b ? 8'h00 : clrCnt + 8'(clrCnt != 8'hFF);
      supCnt <= brownoutSupplyLow ? supCnt + 16'h0001 : 16'h0000;
      if (psel && penable && pwrite && paddr == 12'h000) begin
        cfg <= pwdata[3:0];
      end
    end
  end

  a_power_hold: assert property ($rose(rst_b) |-> !coreReset_b [*8])
    else $error("core left reset too soon after power-on");
  a_wd_drops_core: assert property (watchdogReset |=> !coreReset_b)
    else $error("watchdog pulse did not reset the core");
  a_clear_holds: assert property (clrCnt >= 8'd26 |-> !coreReset_b)
    else $error("long clear pulse did not hold reset");
  a_brownout_holds: assert property (
    cfg[3] && supCnt >= BO_LIM |-> !coreReset_b)
    else $error("long supply dip did not hold reset");
  a_brownout_recover: assert property (
    cfg[3] && $fell(brownoutSupplyLow) && supCnt >= BO_LIM
    |-> !coreReset_b [*8])
    else $error("no delay after supply recovery");
  a_clkout_mode: assert property (
    oscillatorOutputEn == (cfg[1:0] == 2'h3))
    else $error("clock out enable does not follow mode");
  a_cause_change: assert property (
    $changed(resetCause) |-> (!coreReset_b || !$past(coreReset_b)) or
    ##1 !coreReset_b)
    else $error("reset cause changed outside a reset");
  a_unmapped_err: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
    else $error("error response wrong for address");
  a_rdata_hold: assert property (!psel |=> $stable(prdata))
    else $error("read data changed while idle");
endmodule : rts_sequencer_assertions

bind rts_sequencer rts_sequencer_assertions #(
  .BROWNOUT_MIN_CYC(BROWNOUT_MIN_CYC)
) rts_sequencer_assertions_i (.core_clk, .rst_b, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pslverr, .masterClearPin_b,
  .brownoutSupplyLow, .watchdogReset, .coreReset_b, .oscillatorOutputEn,
  .resetCause);

// file: rts_far_model.sv
// Far-side model: oscillator sources and the clear pin driver
`timescale 1ns/1ns
module rts_far_model (
  input wire logic core_clk,
  input wire logic clrLow,
  output logic masterClearPin_b,
  output logic oscillatorInputPin,
  output logic delayOscPin
);
  // External clock on the crystal input, ten core cycles a period
  initial oscillatorInputPin = 1'b0;
  always #50 oscillatorInputPin = ~oscillatorInputPin;
  // Delay oscillator, twenty core cycles a period
  initial delayOscPin = 1'b0;
  always #100 delayOscPin = ~delayOscPin;
  // Clear pin driver; a released pin is pulled up
  initial masterClearPin_b = 1'b1;
  always @(posedge core_clk) masterClearPin_b <= !clrLow;
endmodule : rts_far_model

// file: rts_sequencer_tb.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ns
module rts_sequencer_tb;
  import rts_pkg::*;
  localparam int DLY = 8; // Shortened delay tick count
  localparam int STU = 4; // Shortened startup count
  localparam int BOM = 5; // Shortened brownout minimum
  localparam int DP = 20; // Delay oscillator period in cycles
  localparam int OP = 10; // Main oscillator period in cycles
  // One register access and what it should give
  typedef struct {
    logic w;
    logic [11:0] a;
    logic [31:0] d, x;
    logic e;
  } rts_row_t;
  logic core_clk = 1'b0, rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, clrLow = 1'b0;
  logic brownoutSupplyLow = 1'b0, watchdogReset = 1'b0;
  logic watchdogWake = 1'b0, interruptWake = 1'b0, coreSleeping = 1'b0;
  logic masterClearPin_b, oscillatorInputPin, delayOscPin;
  logic coreReset_b, coreStall, oscillatorOutputPin, oscillatorOutputEn;
  rts_cause_t resetCause;
  int failures = 0, num_checks = 0, n;
  rts_row_t rows [9] = '{
    '{1'b0, 12'h000, 32'h0, 32'hD, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h3, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h008, 32'h3, 32'h0, 1'b0},
    '{1'b1, 12'h004, 32'hFF, 32'h0, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h3, 1'b0},
    '{1'b1, 12'h00C, 32'h1, 32'h0, 1'b1},
    '{1'b0, 12'h00C, 32'h0, 32'h0, 1'b1},
    '{1'b0, 12'h008, 32'h0, 32'h3, 1'b0}};

  rts_sequencer #(.DELAY_TICKS(DLY), .STARTUP_CYCLES(STU),
    .BROWNOUT_MIN_CYC(BOM)) rts_sequencer_i (.core_clk, .rst_b, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .masterClearPin_b, .oscillatorInputPin, .delayOscPin,
    .brownoutSupplyLow, .watchdogReset, .watchdogWake, .interruptWake,
    .coreSleeping, .coreReset_b, .coreStall, .oscillatorOutputPin,
    .oscillatorOutputEn, .resetCause);
  rts_far_model rts_far_model_i (.core_clk, .clrLow, .masterClearPin_b,
    .oscillatorInputPin, .delayOscPin);

  // Core clock
  always #5 core_clk = ~core_clk;

  // Verdict and end of run
  task automatic end_sim(input logic t);
    failures += int'(t);
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Count compare against a window
  task automatic chkRange(input int c, input int lo, input int hi);
    num_checks++;
    if (c < lo || c > hi) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, c, lo, hi);
    end
  endtask : chkRange

  // One APB transfer; result left in rd and er
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) end_sim(1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // Cycles until core reset reaches a level, left in n
  task automatic waitRst(input logic v);
    n = 0;
    while (coreReset_b !== v && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 1000) end_sim(1'b1);
  endtask : waitRst

  // Supply dip of a given length
  task automatic dip(input int len);
    brownoutSupplyLow <= 1'b1;
    repeat (len) @(posedge core_clk);
    brownoutSupplyLow <= 1'b0;
  endtask : dip

  // Clear pin pulse, optionally with the core asleep
  task automatic clear(input int len, input logic sl);
    coreSleeping <= sl;
    clrLow <= 1'b1;
    repeat (len) @(posedge core_clk);
    chk(32'(coreReset_b), 32'(len < 15));
    clrLow <= 1'b0;
    waitRst(1'b1);
    chkRange(n, 0, 10);
    coreSleeping <= 1'b0;
  endtask : clear

  // Wake from sleep; counts stalled cycles
  task automatic wake(input logic wdt, input int lo, input int hi);
    int t;
    t = 0;
    coreSleeping <= 1'b1;
    @(posedge core_clk);
    watchdogWake <= wdt;
    interruptWake <= !wdt;
    @(posedge core_clk);
    watchdogWake <= 1'b0;
    interruptWake <= 1'b0;
    repeat (80) begin
      @(posedge core_clk);
      t += int'(coreStall === 1'b1);
    end
    coreSleeping <= 1'b0;
    chkRange(t, lo, hi);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h3, 32'h0);
  endtask : wake

  // Main sequence
  initial begin
    int t;
    logic p;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    waitRst(1'b1);
    chkRange(n, (DLY-1)*DP + (STU-1)*OP, DLY*DP + STU*OP + 12);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(32'(er), 32'(rows[i].e));
      if (!rows[i].w) chk(rd, rows[i].x);
    end
    // Short dip ignored; a dip during the delay restarts it
    dip(BOM - 3);
    repeat (20) @(posedge core_clk);
    chk(32'(coreReset_b), 32'h1);
    dip(30);
    chk(32'(coreReset_b), 32'h0);
    repeat (60) @(posedge core_clk);
    dip(30);
    waitRst(1'b1);
    chkRange(n, (DLY-1)*DP, DLY*DP + 12);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h70, 32'h40);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h2);
    // Brownout disabled: dips do nothing
    apb(1'b1, 12'h000, 32'h5);
    dip(30);
    repeat (3) @(posedge core_clk);
    chk(32'(coreReset_b), 32'h1);
    clear(10, 1'b0);
    clear(40, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h70, 32'h10);
    clear(40, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h72, 32'h20);
    watchdogReset <= 1'b1;
    @(posedge core_clk);
    watchdogReset <= 1'b0;
    repeat (5) @(posedge core_clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h71, 32'h30);
    wake(1'b1, (STU-1)*OP, STU*OP + 12);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h000, 32'h4 + 32'(m));
      chk(32'(oscillatorOutputEn), 32'(m == 3));
    end
    wake(1'b0, 0, 0);
    // Clock out toggles twice per four input periods
    t = 0;
    p = oscillatorOutputPin;
    repeat (400) begin
      @(posedge core_clk);
      t += int'(oscillatorOutputPin !== p);
      p = oscillatorOutputPin;
    end
    chkRange(t, 18, 22);
    // Second power-on in mid-run
    rst_b <= 1'b0;
    @(posedge core_clk);
    chk(32'({coreReset_b, resetCause}), 32'h0);
    repeat (11) @(posedge core_clk);
    rst_b <= 1'b1;
    waitRst(1'b1);
    chkRange(n, (DLY-1)*DP + (STU-1)*OP, DLY*DP + STU*OP + 12);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'hD);
    end_sim(1'b0);
  end
endmodule : rts_sequencer_tb
